// *** serial_decode_pkg.sv ***
// constants, types and helpers for the quad serial port address and irq decoder
//
// Behaviour
// R1 - legacy mapping decodes ports one to four at eight-byte blocks at 3F8, 2F8, 3E8 and 2E8.
// R2 - relocatable mapping places ports one to four at base plus 00, 08, 10 and 18, eight bytes each.
// R3 - one mapping-select bit chooses legacy or relocatable addressing for all four ports.
// R4 - the relocatable base runs from 200 to 3F8 in steps of eight, A3 to A8 each from a switch.
// R5 - A9 is never switch-selected and must always be one for any port to decode.
// R6 - per-port offsets from the base are fixed; only the base moves the ports.
// R7 - an irq-sharing bit selects one common line or one line per port.
// R8 - in per-port mode port n drives only the host irq line chosen by its own jumper bank.
// R9 - in shared mode all four port interrupts drive the line chosen by the first jumper bank.
// R10 - a jumper bank offers host irq lines 3, 4, 5, 6, 7, 9, 10, 11, 12 and 15 only.
// R11 - after reset the mapping is relocatable at 300, irqs shared on line 5, speed one-times.
// R12 - several cards in shared mode on one bus must each be given a different irq line.
// R13 - each port supports five to eight data bits, 1, 1.5 or 2 stop bits, none, even or odd parity.
// R14 - an open base-address switch reads as one for its address bit, a closed one as zero.
// R15 - a chip select asserts only for a non-DMA i/o cycle whose A9 to A3 match the port's block.
package serial_decode_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] JUMPER_OFS = 8'h04;
  localparam logic [7:0] FRAME_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] ENABLE_OFS = 8'h10;
  localparam logic [7:0] CLEAR_OFS  = 8'h14;
  localparam logic [7:0] STATE_OFS  = 8'h18;

  // ==========================================================================
  // field layout and reset values
  localparam int NUM_PORTS   = 4;
  localparam int SW_MAP_BIT  = 0;
  localparam int SW_SHARE_BIT = 1;
  localparam int SW_SPEED_BIT = 2;
  localparam int SW_ADDR_LSB = 3;
  localparam int JUMPER_W    = 4;
  localparam int FRAME_W     = 8;
  localparam logic [5:0] ADDR_SW_RST  = 6'h20;
  localparam logic       MAP_RST      = 1'b1;
  localparam logic       SHARE_RST    = 1'b1;
  localparam logic       SPEED_RST    = 1'b0;
  localparam logic [3:0] JUMPER_RST   = 4'h2;
  localparam logic [4:0] FRAME_RST    = 5'h03;

  // ==========================================================================
  // address map, in units of eight bytes (A9..A3)
  localparam logic [6:0] LEGACY_BLK [NUM_PORTS] = '{7'h7F, 7'h5F, 7'h7D, 7'h5D};
  localparam logic [6:0] RELOC_STEP [NUM_PORTS] = '{7'h00, 7'h01, 7'h02, 7'h03};

  // ==========================================================================
  // types
  typedef struct packed {
    logic [5:0] address_switch_bank;
    logic       speed_8x;
    logic       irq_share_select;
    logic       base_map_select;
  } switch_t;

  typedef struct packed {
    logic       parity_even;
    logic       parity_en;
    logic       two_stop;
    logic [1:0] data_bits;
  } frame_t;

  typedef struct packed {
    logic [9:0] addr;
    logic       aen;
    logic       ior_n;
    logic       iow_n;
  } host_bus_t;

  // jumper index to one-hot host irq line, illegal index selects none
  function automatic logic [15:0] irq_line_of(input logic [3:0] idx);
    logic [15:0] line;
    line = 16'h0000;
    unique case (idx)
      4'h0:    line = 16'h0008;
      4'h1:    line = 16'h0010;
      4'h2:    line = 16'h0020;
      4'h3:    line = 16'h0040;
      4'h4:    line = 16'h0080;
      4'h5:    line = 16'h0200;
      4'h6:    line = 16'h0400;
      4'h7:    line = 16'h0800;
      4'h8:    line = 16'h1000;
      4'h9:    line = 16'h8000;
      default: line = 16'h0000;
    endcase
    return line;
  endfunction

endpackage

// *** serial_decode.sv ***
// host-bus address decoder and interrupt router for four serial ports
`timescale 1ns/10ps
`default_nettype none
module serial_decode (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [7:0]                          paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire serial_decode_pkg::host_bus_t        host_bus,
  input  wire logic [3:0]                          uart_irq,
  output logic      [3:0]                          port_cs,
  output logic      [15:0]                         host_irq,
  output serial_decode_pkg::frame_t [3:0]          port_frame,
  output logic                                     speed_8x,
  output logic                                     irq
);

  // ==========================================================================
  // configuration and interrupt registers
  serial_decode_pkg::switch_t      sw_q;
  logic [3:0][3:0]                 jumper_q;
  serial_decode_pkg::frame_t [3:0] frame_q;
  logic [3:0]                      status_q;
  logic [3:0]                      enable_q;
  logic [3:0]                      uart_irq_q;
  logic [3:0]                      port_cs_q;
  logic [31:0]                     prdata_q;
  logic                            pready_q;
  logic                            pslverr_q;
  logic [31:0]                     rd_d;
  logic                            hit_d;
  logic                            setup;
  logic                            wr_en;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite;

  // read mux and decode, evaluated in the setup cycle
  always_comb begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    unique case (paddr)
      serial_decode_pkg::CFG_OFS:    rd_d = {23'h000000, sw_q};
      serial_decode_pkg::JUMPER_OFS: rd_d = {16'h0000, jumper_q};
      serial_decode_pkg::FRAME_OFS: begin
        for (int i = 0; i < serial_decode_pkg::NUM_PORTS; i++) begin
          rd_d[i*serial_decode_pkg::FRAME_W +: 5] = frame_q[i];
        end
      end
      serial_decode_pkg::STATUS_OFS: rd_d = {28'h0000000, status_q};
      serial_decode_pkg::ENABLE_OFS: rd_d = {28'h0000000, enable_q};
      serial_decode_pkg::CLEAR_OFS:  rd_d = 32'h0000_0000;
      serial_decode_pkg::STATE_OFS:  rd_d = {24'h000000, uart_irq_q, port_cs_q};
      default:                       hit_d = 1'b0;
    endcase
  end

  // zero-wait answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !hit_d;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  // software view of the switches and jumper banks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q.base_map_select     <= serial_decode_pkg::MAP_RST;       // R11
      sw_q.irq_share_select    <= serial_decode_pkg::SHARE_RST;     // R11
      sw_q.speed_8x            <= serial_decode_pkg::SPEED_RST;     // R11
      sw_q.address_switch_bank <= serial_decode_pkg::ADDR_SW_RST;   // R11
      jumper_q                 <= {4{serial_decode_pkg::JUMPER_RST}}; // R11
    end else if (wr_en && paddr == serial_decode_pkg::CFG_OFS) begin
      sw_q <= pwdata[8:0];
    end else if (wr_en && paddr == serial_decode_pkg::JUMPER_OFS) begin
      jumper_q <= pwdata[15:0];
    end
  end

  // per-port character framing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q <= {4{serial_decode_pkg::FRAME_RST}};
    end else if (wr_en && paddr == serial_decode_pkg::FRAME_OFS) begin
      for (int i = 0; i < serial_decode_pkg::NUM_PORTS; i++) begin
        frame_q[i] <= pwdata[i*serial_decode_pkg::FRAME_W +: 5]; // R13
      end
    end
  end

  // sticky status on port interrupt rising edge, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_irq_q <= 4'h0;
      status_q   <= 4'h0;
      enable_q   <= 4'h0;
    end else begin
      uart_irq_q <= uart_irq;
      if (wr_en && paddr == serial_decode_pkg::ENABLE_OFS) begin
        enable_q <= pwdata[3:0];
      end
      status_q <= (status_q & ~((wr_en && paddr == serial_decode_pkg::CLEAR_OFS) ?
                  pwdata[3:0] : 4'h0)) | (uart_irq & ~uart_irq_q);
    end
  end

  // ==========================================================================
  // host bus synchroniser
  serial_decode_pkg::host_bus_t bus_s1_q;
  serial_decode_pkg::host_bus_t bus_s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_s1_q <= '{addr: 10'h000, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
      bus_s2_q <= '{addr: 10'h000, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
    end else begin
      bus_s1_q <= host_bus;
      bus_s2_q <= bus_s1_q;
    end
  end

  // ==========================================================================
  // port address decode
  logic       io_cycle;
  logic [6:0] base_blk;
  logic [3:0] cs_d;

  assign io_cycle = (!bus_s2_q.ior_n || !bus_s2_q.iow_n) && !bus_s2_q.aen; // R15
  // A9 hardwired high, open switch gives a one
  assign base_blk = {1'b1, sw_q.address_switch_bank}; // R4 R5 R14

  generate
    for (genvar p = 0; p < serial_decode_pkg::NUM_PORTS; p++) begin : g_dec
      logic [6:0] blk;
      assign blk = sw_q.base_map_select ?
                   7'(base_blk + serial_decode_pkg::RELOC_STEP[p]) : // R2 R6
                   serial_decode_pkg::LEGACY_BLK[p];               // R1
      assign cs_d[p] = io_cycle && bus_s2_q.addr[9] &&              // R5
                       bus_s2_q.addr[9:3] == blk;                   // R3 R15
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_cs_q <= 4'h0;
    end else begin
      port_cs_q <= cs_d; // R15
    end
  end

  // ==========================================================================
  // interrupt routing
  logic [15:0] route_d;
  logic [15:0] host_irq_q;
  logic        irq_q;

  always_comb begin
    route_d = 16'h0000;
    if (sw_q.irq_share_select) begin
      if (|uart_irq) begin
        route_d = serial_decode_pkg::irq_line_of(jumper_q[0]); // R7 R9 R10
      end
    end else begin
      for (int i = 0; i < serial_decode_pkg::NUM_PORTS; i++) begin
        if (uart_irq[i]) begin
          route_d = route_d | serial_decode_pkg::irq_line_of(jumper_q[i]); // R7 R8 R10
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_irq_q <= 16'h0000;
      irq_q      <= 1'b0;
    end else begin
      host_irq_q <= route_d;
      irq_q      <= |(status_q & enable_q);
    end
  end

  // ==========================================================================
  // outputs
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign port_cs    = port_cs_q;
  assign host_irq   = host_irq_q;
  assign port_frame = frame_q;
  assign speed_8x   = sw_q.speed_8x;
  assign irq        = irq_q;

  // ==========================================================================
  // checks
  a_legacy_cs_map: assert property (@(posedge pclk) disable iff (!presetn) // R1
    io_cycle && !sw_q.base_map_select && bus_s2_q.addr == 10'h3F8 |=> port_cs_q == 4'h1)
    else $error("legacy port one not selected at 3F8");

  a_reloc_cs_port4: assert property (@(posedge pclk) disable iff (!presetn) // R2
    io_cycle && sw_q.base_map_select && sw_q.address_switch_bank == 6'h20 &&
    bus_s2_q.addr[9:3] == 7'h63 |=> port_cs_q == 4'h8)
    else $error("port four not at base plus 18");

  a_a9_low_idle: assert property (@(posedge pclk) disable iff (!presetn) // R5
    !bus_s2_q.addr[9] |=> port_cs_q == 4'h0)
    else $error("select with A9 low");

  a_dma_no_cs: assert property (@(posedge pclk) disable iff (!presetn) // R15
    bus_s2_q.aen || (bus_s2_q.ior_n && bus_s2_q.iow_n) |=> port_cs_q == 4'h0)
    else $error("select outside an i/o cycle");

  a_cs_onehot: assert property (@(posedge pclk) disable iff (!presetn) // R6
    $onehot0(port_cs_q))
    else $error("two ports selected");

  a_shared_route: assert property (@(posedge pclk) disable iff (!presetn) // R9
    sw_q.irq_share_select && uart_irq != 4'h0 && jumper_q[0] == 4'h2 &&
    $stable(sw_q) |=> host_irq_q == 16'h0020)
    else $error("shared irq not on line five");

  a_legal_lines: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (host_irq_q & 16'h6107) == 16'h0000)
    else $error("illegal host irq line driven");

  a_indep_route: assert property (@(posedge pclk) disable iff (!presetn) // R8
    !sw_q.irq_share_select && uart_irq == 4'h4 && jumper_q[2] == 4'h9 &&
    $stable(jumper_q) |=> host_irq_q == 16'h8000)
    else $error("port three irq misrouted");

  a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn) // sticky status
    (uart_irq[0] && !uart_irq_q[0]) ||
    (status_q[0] && !(wr_en && paddr == serial_decode_pkg::CLEAR_OFS && pwdata[0]))
    |=> status_q[0])
    else $error("status bit not set or not held");

  a_ready_once: assert property (@(posedge pclk) disable iff (!presetn) // one-cycle apb ready
    setup |=> pready_q ##1 !pready_q || setup)
    else $error("apb answer not one cycle");

  a_legacy_port2: assert property (@(posedge pclk) disable iff (!presetn) // R1
    io_cycle && !sw_q.base_map_select && bus_s2_q.addr[9:3] == 7'h5F |=> port_cs_q == 4'h2)
    else $error("legacy port two not selected at 2F8");

  a_legacy_port3: assert property (@(posedge pclk) disable iff (!presetn) // R1
    io_cycle && !sw_q.base_map_select && bus_s2_q.addr[9:3] == 7'h7D |=> port_cs_q == 4'h4)
    else $error("legacy port three not selected at 3E8");

  a_legacy_port4: assert property (@(posedge pclk) disable iff (!presetn) // R1
    io_cycle && !sw_q.base_map_select && bus_s2_q.addr[9:3] == 7'h5D |=> port_cs_q == 4'h8)
    else $error("legacy port four not selected at 2E8");

  a_legacy_no_base: assert property (@(posedge pclk) disable iff (!presetn) // R3
    io_cycle && !sw_q.base_map_select && bus_s2_q.addr[9:3] == 7'h60 |=> port_cs_q == 4'h0)
    else $error("legacy mode decoded the relocatable base");

  a_reloc_default_port1: assert property (@(posedge pclk) disable iff (!presetn) // R2 R11
    io_cycle && sw_q.base_map_select && sw_q.address_switch_bank == 6'h20 &&
    bus_s2_q.addr[9:3] == 7'h60 |=> port_cs_q == 4'h1)
    else $error("port one not at base 300");

  a_reloc_low_base: assert property (@(posedge pclk) disable iff (!presetn) // R4 R14
    io_cycle && sw_q.base_map_select && sw_q.address_switch_bank == 6'h00 &&
    bus_s2_q.addr[9:3] == 7'h43 |=> port_cs_q == 4'h8)
    else $error("port four not at 218 with all switches closed");

  a_reloc_top_base: assert property (@(posedge pclk) disable iff (!presetn) // R4 R14
    io_cycle && sw_q.base_map_select && sw_q.address_switch_bank == 6'h3F &&
    bus_s2_q.addr[9:3] == 7'h7F |=> port_cs_q == 4'h1)
    else $error("port one not at 3F8 with all switches open");

  a_shared_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R7
    sw_q.irq_share_select && uart_irq == 4'h0 |=> host_irq_q == 16'h0000)
    else $error("shared line driven with no port interrupt");

  a_shared_line3: assert property (@(posedge pclk) disable iff (!presetn) // R9 R10
    sw_q.irq_share_select && uart_irq != 4'h0 && jumper_q[0] == 4'h0
    |=> host_irq_q == 16'h0008)
    else $error("shared irq not on line three");

  a_bad_jumper_none: assert property (@(posedge pclk) disable iff (!presetn) // R10
    sw_q.irq_share_select && jumper_q[0] > 4'h9 |=> host_irq_q == 16'h0000)
    else $error("unlisted jumper index drove a line");

  a_indep_pair: assert property (@(posedge pclk) disable iff (!presetn) // R8
    !sw_q.irq_share_select && uart_irq == 4'h6 && jumper_q[1] == 4'h1 &&
    jumper_q[2] == 4'h9 |=> host_irq_q == 16'h8010)
    else $error("ports two and three misrouted");

endmodule
`default_nettype wire

// *** serial_host_model.sv ***
// host cpu model driving isa-style i/o cycles
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  input  wire logic                    pclk,
  output serial_decode_pkg::host_bus_t host_bus
);
  // ==========================================================
  // idle bus, strobes high
  initial host_bus = '{addr: 10'h000, aen: 1'b0, ior_n: 1'b1, iow_n: 1'b1};
  // single card on this bus, so its irq line is unshared
  task automatic io_start(input logic [9:0] a, input logic dma, input logic wr);
    @(posedge pclk);
    host_bus <= '{addr: a, aen: dma, ior_n: wr, iow_n: !wr};
  endtask
  // released address shows a changed pattern
  task automatic io_end();
    host_bus <= '{addr: ~host_bus.addr, aen: 1'b0, ior_n: 1'b1, iow_n: 1'b1};
  endtask
endmodule
`default_nettype wire

// *** serial_decode_tb_top.sv ***
// testbench for the serial port decoder
`timescale 1ns/10ps
`default_nettype none
module serial_decode_tb_top;
  logic                            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                            speed_8x, irq, err;
  logic [7:0]                      paddr;
  logic [31:0]                     pwdata, prdata, rd;
  logic [3:0]                      uart_irq, port_cs;
  logic [15:0]                     host_irq;
  serial_decode_pkg::host_bus_t    host_bus;
  serial_decode_pkg::frame_t [3:0] port_frame;
  int                              n_mismatch, checks_done, cyc;
  localparam logic [15:0] LINE_TBL [10] = '{16'h0008, 16'h0010, 16'h0020, 16'h0040,
    16'h0080, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h8000};
  localparam logic [9:0] LEG_ADR [4] = '{10'h3F8, 10'h2F8, 10'h3E8, 10'h2E8};

  serial_decode dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_bus(host_bus), .uart_irq(uart_irq), .port_cs(port_cs),
    .host_irq(host_irq), .port_frame(port_frame), .speed_8x(speed_8x), .irq(irq));
  serial_host_model host (.pclk(pclk), .host_bus(host_bus));

  // ==========================================================
  // clock, timeout and helpers
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic dec(input logic [9:0] a, input logic dma, input logic [3:0] exp);
    host.io_start(a, dma, 1'b0);
    repeat (4) @(posedge pclk);
    chk("port_cs", {28'h0, port_cs}, {28'h0, exp});
    host.io_end();
    repeat (4) @(posedge pclk);
    chk("port_cs idle", {28'h0, port_cs}, 32'h0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, uart_irq} = '0;
    {n_mismatch, checks_done, cyc} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("cfg", rd, 32'h0000_0103);
    apb(1'b0, 8'h04, 32'h0);
    chk("jumper", rd, 32'h0000_2222);
    apb(1'b0, 8'h08, 32'h0);
    chk("frame", rd, 32'h0303_0303);
    chk("speed_8x", {31'h0, speed_8x}, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    $display("test reset done");
    for (int p = 0; p < 4; p++) dec(10'h307 + 10'(8 * p), 1'b0, 4'(1 << p));
    dec(10'h300, 1'b1, 4'h0);
    dec(10'h100, 1'b0, 4'h0);
    apb(1'b1, 8'h00, 32'h0000_01FB);
    dec(10'h3F8, 1'b0, 4'h1);
    dec(10'h1F8, 1'b0, 4'h0);
    apb(1'b1, 8'h00, 32'h0000_0003);
    dec(10'h218, 1'b0, 4'h8);
    apb(1'b1, 8'h00, 32'h0000_0102);
    for (int p = 0; p < 4; p++) dec(LEG_ADR[p], 1'b0, 4'(1 << p));
    dec(10'h300, 1'b0, 4'h0);
    $display("test decode done");
    apb(1'b1, 8'h08, 32'h031A_0D04);
    chk("port_frame", {12'h0, port_frame}, 32'h0001_E9A4);
    apb(1'b1, 8'h00, 32'h0000_0107);
    chk("speed_8x", {31'h0, speed_8x}, 32'h1);
    apb(1'b1, 8'h00, 32'h0000_0103);
    uart_irq <= 4'h1;
    repeat (3) @(posedge pclk);
    chk("host_irq", {16'h0, host_irq}, 32'h0000_0020);
    for (int j = 0; j < 11; j++) begin
      apb(1'b1, 8'h04, {28'h0, 4'(j)});
      chk("host_irq", {16'h0, host_irq}, {16'h0, (j < 10) ? LINE_TBL[j] : 16'h0});
    end
    apb(1'b1, 8'h04, 32'h0000_0003);
    uart_irq <= 4'h2;
    repeat (3) @(posedge pclk);
    chk("host_irq", {16'h0, host_irq}, 32'h0000_0040);
    apb(1'b1, 8'h00, 32'h0000_0101);
    apb(1'b1, 8'h04, 32'h0000_5910);
    uart_irq <= 4'h6;
    repeat (3) @(posedge pclk);
    chk("host_irq", {16'h0, host_irq}, 32'h0000_8010);
    uart_irq <= 4'h4;
    repeat (3) @(posedge pclk);
    chk("host_irq", {16'h0, host_irq}, 32'h0000_8000);
    apb(1'b0, 8'h0C, 32'h0);
    chk("status", rd, 32'h7);
    apb(1'b1, 8'h10, 32'h8);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, 8'h10, 32'h4);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, 8'h14, 32'h4);
    apb(1'b0, 8'h0C, 32'h0);
    chk("status cleared", rd, 32'h3);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("state", rd, 32'h0000_0040);
    apb(1'b0, 8'h14, 32'h0);
    chk("clear reads zero", rd, 32'h0);
    $display("test irq done");
    finish_test();
  end
endmodule
`default_nettype wire
